// [microstep_wave_spi_out.sv]
// Microstep current wave generator with serial datagram output to a motor driver
`timescale 1ns/100ps
module microstep_wave_spi_out
	import microstep_wave_pkg::*;
#(
	parameter int ADDR_WIDTH = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Internal steps from the ramp generator
	input wire logic step_i,
	input wire logic direction_i,
	// Wave outputs
	output logic [9:0] microstep_counter_o,
	output logic [8:0] phase_a_current_o,
	output logic [8:0] phase_b_current_o,
	// Serial link to the driver
	output logic driver_select_n_o,
	output logic driver_serial_clock_o,
	output logic driver_data_out_o,
	input wire logic driver_data_in_i
);

	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] general_config_reg;
	serial_cfg_type serial_cfg_reg;
	segment_select_type segment_select_reg;
	logic [31:0] start_values_reg;
	logic [31:0] wave_table_reg [0:7];
	logic [31:0] response_reg;
	logic [9:0] counter_reg;
	logic [7:0] mag_a_reg;
	logic [7:0] mag_b_reg;
	logic [8:0] cur_a_reg;
	logic [8:0] cur_b_reg;
	logic pending_reg;
	link_state_type state_reg;
	logic [3:0] timer_reg;
	logic [5:0] bit_reg;
	logic [31:0] shift_reg;
	logic [31:0] capture_reg;
	driver_pins_type pins_reg;
	logic din_meta_reg;
	logic din_sync_reg;

	logic [7:0] word_idx;
	logic bus_req;
	logic [31:0] rd_mux;
	logic [9:0] counter_next;
	logic [7:0] mag_a_next;
	logic [7:0] mag_b_next;
	logic [8:0] cur_a_next;
	logic [8:0] cur_b_next;
	logic [255:0] ofs_bits;
	logic [3:0] eff_low;
	logic [3:0] eff_high;
	logic [3:0] eff_block;
	logic serial_enable;

	assign word_idx = 8'(wb_adr_i >> 2);
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign serial_enable = ~general_config_reg[SERIAL_ENC_OUT_SELECT_BIT];

	// Flatten the offset bits, bit j belongs to table step j
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_ofs
			assign ofs_bits[gi*32 +: 32] = wave_table_reg[gi];
		end
	endgenerate

	// Byte lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Increment of quarter step j: slope of its segment plus offset bit minus one
	function automatic logic signed [3:0] step_inc(input segment_select_type s, input logic [255:0] ofs,
		input logic [7:0] j);
		logic [1:0] slope;
		slope = s.slope_seg3;
		if (j < s.first_border) begin
			slope = s.slope_seg0;
		end else if (j < s.second_border) begin
			slope = s.slope_seg1;
		end else if (j < s.third_border) begin
			slope = s.slope_seg2;
		end
		return $signed({2'b00, slope}) + $signed({3'b000, ofs[j]}) - 4'sd1;
	endfunction

	// Magnitude change when moving between positions p and p+1 (low is p), in the given direction
	function automatic logic [7:0] mag_move(input logic [7:0] mag, input logic [9:0] low, input logic up,
		input segment_select_type s, input logic [255:0] ofs);
		logic [7:0] j;
		logic signed [3:0] inc;
		logic rising;
		j = low[8] ? 8'(8'hff - low[7:0]) : low[7:0];
		inc = step_inc(s, ofs, j);
		rising = (~low[8]) ~^ up;
		if (rising) begin
			return 8'($signed({1'b0, mag}) + inc);
		end
		return 8'($signed({1'b0, mag}) - inc);
	endfunction

	// Sign from the half of the period
	function automatic logic [8:0] signed_cur(input logic [7:0] mag, input logic [9:0] pos);
		if (pos[9]) begin
			return 9'(-$signed({1'b0, mag}));
		end
		return {1'b0, mag};
	endfunction

	// Wave stepping
	always_comb begin
		logic [9:0] low_a;
		low_a = 10'h000;
		counter_next = counter_reg;
		mag_a_next = mag_a_reg;
		mag_b_next = mag_b_reg;
		if (step_i) begin
			counter_next = direction_i ? 10'(counter_reg + 10'h001) : 10'(counter_reg - 10'h001);
			low_a = direction_i ? counter_reg : counter_next;
			mag_a_next = mag_move(mag_a_reg, low_a, direction_i, segment_select_reg, ofs_bits);
			mag_b_next = mag_move(mag_b_reg, 10'(low_a + SECOND_PHASE_OFFSET), direction_i,
				segment_select_reg, ofs_bits);
			if (counter_next == FIRST_PHASE_START_POS) begin
				mag_a_next = start_values_reg[FIRST_START_LSB +: 8];
				mag_b_next = start_values_reg[SECOND_START_LSB +: 8];
			end
		end
		cur_a_next = signed_cur(mag_a_next, counter_next);
		cur_b_next = signed_cur(mag_b_next, 10'(counter_next + SECOND_PHASE_OFFSET));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_reg <= FIRST_PHASE_START_POS;
			mag_a_reg <= WAVE_START_VALUES_RESET[FIRST_START_LSB +: 8];
			mag_b_reg <= WAVE_START_VALUES_RESET[SECOND_START_LSB +: 8];
			cur_a_reg <= {1'b0, WAVE_START_VALUES_RESET[FIRST_START_LSB +: 8]};
			cur_b_reg <= {1'b0, WAVE_START_VALUES_RESET[SECOND_START_LSB +: 8]};
		end else begin
			counter_reg <= counter_next;
			mag_a_reg <= mag_a_next;
			mag_b_reg <= mag_b_next;
			cur_a_reg <= cur_a_next;
			cur_b_reg <= cur_b_next;
		end
	end

	assign microstep_counter_o = counter_reg;
	assign phase_a_current_o = cur_a_reg;
	assign phase_b_current_o = cur_b_reg;

	// Read multiplexer
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (word_idx == IDX_GENERAL_CONFIG) begin
			rd_mux = general_config_reg;
		end else if (word_idx == IDX_SERIAL_OUTPUT_CONFIG) begin
			rd_mux = serial_cfg_reg;
		end else if (word_idx == IDX_DATAGRAM_RESPONSE) begin
			rd_mux = response_reg;
		end else if (word_idx == IDX_SERIAL_STATUS) begin
			rd_mux = {30'h0000_0000, pending_reg, state_reg != LINK_IDLE};
		end else if (word_idx >= IDX_WAVE_TABLE_FIRST && word_idx <= IDX_WAVE_TABLE_LAST) begin
			rd_mux = wave_table_reg[word_idx[2:0]];
		end else if (word_idx == IDX_WAVE_SEGMENT_SELECT) begin
			rd_mux = segment_select_reg;
		end else if (word_idx == IDX_MICROSTEP_COUNTER) begin
			rd_mux = {22'h00_0000, counter_reg};
		end else if (word_idx == IDX_PHASE_CURRENTS) begin
			rd_mux = {7'h00, cur_b_reg, 7'h00, cur_a_reg};
		end else if (word_idx == IDX_WAVE_START_VALUES) begin
			rd_mux = start_values_reg;
		end
	end

	// Bus handshake: one wait state, ack drops the cycle after it is given
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			if (bus_req & ~ack_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// Register writes take effect at the acknowledging edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			general_config_reg <= GENERAL_CONFIG_RESET;
			serial_cfg_reg <= SERIAL_OUTPUT_CONFIG_RESET;
			segment_select_reg <= WAVE_SEGMENT_SELECT_RESET;
			start_values_reg <= WAVE_START_VALUES_RESET;
			for (int i = 0; i < 8; i++) begin
				wave_table_reg[i] <= WAVE_TABLE_RESET;
			end
		end else if (bus_req & ack_reg & wb_we_i) begin
			if (word_idx == IDX_GENERAL_CONFIG) begin
				general_config_reg <= merge(general_config_reg, wb_dat_i, wb_sel_i);
			end else if (word_idx == IDX_SERIAL_OUTPUT_CONFIG) begin
				serial_cfg_reg <= merge(serial_cfg_reg, wb_dat_i, wb_sel_i);
			end else if (word_idx >= IDX_WAVE_TABLE_FIRST && word_idx <= IDX_WAVE_TABLE_LAST) begin
				wave_table_reg[word_idx[2:0]] <= merge(wave_table_reg[word_idx[2:0]], wb_dat_i, wb_sel_i);
			end else if (word_idx == IDX_WAVE_SEGMENT_SELECT) begin
				segment_select_reg <= merge(segment_select_reg, wb_dat_i, wb_sel_i);
			end else if (word_idx == IDX_WAVE_START_VALUES) begin
				start_values_reg <= merge(start_values_reg, wb_dat_i, wb_sel_i);
			end
		end
	end

	// Timing fields below two are stretched to two; four bits cap them at fifteen
	assign eff_low = (serial_cfg_reg.low_time < TIMING_MIN_CYCLES) ? TIMING_MIN_CYCLES :
		serial_cfg_reg.low_time;
	assign eff_high = (serial_cfg_reg.high_time < TIMING_MIN_CYCLES) ? TIMING_MIN_CYCLES :
		serial_cfg_reg.high_time;
	assign eff_block = (serial_cfg_reg.block_time < TIMING_MIN_CYCLES) ? TIMING_MIN_CYCLES :
		serial_cfg_reg.block_time;

	// Response pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			din_meta_reg <= 1'b0;
			din_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= driver_data_in_i;
			din_sync_reg <= din_meta_reg;
		end
	end

	// A changed current asks for a datagram; a new change while busy is kept, the newest value is sent
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pending_reg <= 1'b0;
		end else if (serial_enable && (cur_a_next != cur_a_reg || cur_b_next != cur_b_reg)) begin
			pending_reg <= 1'b1;
		end else if (state_reg == LINK_IDLE && pending_reg) begin
			pending_reg <= 1'b0;
		end
	end

	// Serial master: clock idles high, data changes on falling edge, response sampled as the high phase ends
	// The synchronised response lags the pin by two cycles, within the low and high phases of at least four cycles together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= LINK_IDLE;
			timer_reg <= 4'h0;
			bit_reg <= 6'h00;
			shift_reg <= 32'h0000_0000;
			capture_reg <= 32'h0000_0000;
			response_reg <= 32'h0000_0000;
			pins_reg <= '{select_n: 1'b1, serial_clock: 1'b1, data_out: 1'b1};
		end else begin
			case (state_reg)
				LINK_IDLE: begin
					pins_reg.select_n <= 1'b1;
					pins_reg.serial_clock <= 1'b1;
					if (pending_reg && serial_enable) begin
						shift_reg <= {7'h00, cur_b_reg, 7'h00, cur_a_reg};
						pins_reg.select_n <= 1'b0;
						pins_reg.data_out <= 1'b0;
						timer_reg <= 4'(eff_low - 4'h1);
						bit_reg <= 6'(DATAGRAM_BITS - 1);
						state_reg <= LINK_SETUP;
					end
				end
				LINK_SETUP: begin
					if (timer_reg == 4'h0) begin
						pins_reg.serial_clock <= 1'b0;
						pins_reg.data_out <= shift_reg[31];
						timer_reg <= 4'(eff_low - 4'h1);
						state_reg <= LINK_LOW;
					end else begin
						timer_reg <= 4'(timer_reg - 4'h1);
					end
				end
				LINK_LOW: begin
					if (timer_reg == 4'h0) begin
						pins_reg.serial_clock <= 1'b1;
						timer_reg <= 4'(eff_high - 4'h1);
						state_reg <= LINK_HIGH;
					end else begin
						timer_reg <= 4'(timer_reg - 4'h1);
					end
				end
				LINK_HIGH: begin
					if (timer_reg != 4'h0) begin
						timer_reg <= 4'(timer_reg - 4'h1);
					end else if (bit_reg != 6'h00) begin
						pins_reg.serial_clock <= 1'b0;
						pins_reg.data_out <= shift_reg[30];
						capture_reg <= {capture_reg[30:0], din_sync_reg};
						shift_reg <= {shift_reg[30:0], 1'b0};
						bit_reg <= 6'(bit_reg - 6'h01);
						timer_reg <= 4'(eff_low - 4'h1);
						state_reg <= LINK_LOW;
					end else begin
						pins_reg.select_n <= 1'b1;
						capture_reg <= {capture_reg[30:0], din_sync_reg};
						response_reg <= {capture_reg[30:0], din_sync_reg};
						timer_reg <= 4'(eff_block - 4'h1);
						state_reg <= LINK_BLOCK;
					end
				end
				LINK_BLOCK: begin
					if (timer_reg == 4'h0) begin
						state_reg <= LINK_IDLE;
					end else begin
						timer_reg <= 4'(timer_reg - 4'h1);
					end
				end
				default: begin
					state_reg <= LINK_IDLE;
				end
			endcase
		end
	end

	assign driver_select_n_o = pins_reg.select_n;
	assign driver_serial_clock_o = pins_reg.serial_clock;
	assign driver_data_out_o = pins_reg.data_out;

endmodule

// [microstep_wave_pkg.sv]
// Shared constants and types for the microstep wave generator and its serial output
package microstep_wave_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GENERAL_CONFIG = 8'h00;
	localparam logic [7:0] IDX_SERIAL_OUTPUT_CONFIG = 8'h04;
	localparam logic [7:0] IDX_DATAGRAM_RESPONSE = 8'h10;
	localparam logic [7:0] IDX_SERIAL_STATUS = 8'h11;
	localparam logic [7:0] IDX_WAVE_TABLE_FIRST = 8'h70;
	localparam logic [7:0] IDX_WAVE_TABLE_LAST = 8'h77;
	localparam logic [7:0] IDX_WAVE_SEGMENT_SELECT = 8'h78;
	localparam logic [7:0] IDX_MICROSTEP_COUNTER = 8'h79;
	localparam logic [7:0] IDX_PHASE_CURRENTS = 8'h7a;
	localparam logic [7:0] IDX_WAVE_START_VALUES = 8'h7e;

	// Reset values
	localparam logic [31:0] GENERAL_CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] SERIAL_OUTPUT_CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] WAVE_SEGMENT_SELECT_RESET = 32'hffff_8056;
	localparam logic [31:0] WAVE_START_VALUES_RESET = 32'h00f7_0000;
	localparam logic [31:0] WAVE_TABLE_RESET = 32'h0000_0000;

	// Field positions
	localparam int SERIAL_ENC_OUT_SELECT_BIT = 24;
	localparam int FIRST_START_LSB = 0;
	localparam int SECOND_START_LSB = 16;

	// Fixed wave start positions and quarter size
	localparam logic [9:0] FIRST_PHASE_START_POS = 10'h000;
	localparam logic [9:0] SECOND_PHASE_OFFSET = 10'h100;

	// Serial timing limits in system clock cycles
	localparam logic [3:0] TIMING_MIN_CYCLES = 4'h2;

	// Datagram length in bits
	localparam int DATAGRAM_BITS = 32;

	// Output timing fields of the serial output configuration
	typedef struct packed {
		logic [3:0] block_time;
		logic [3:0] high_time;
		logic [3:0] low_time;
		logic [19:0] other;
	} serial_cfg_type;

	// Segment borders and slopes of the compressed quarter wave
	typedef struct packed {
		logic [7:0] third_border;
		logic [7:0] second_border;
		logic [7:0] first_border;
		logic [1:0] slope_seg3;
		logic [1:0] slope_seg2;
		logic [1:0] slope_seg1;
		logic [1:0] slope_seg0;
	} segment_select_type;

	// Serial link pin group
	typedef struct packed {
		logic select_n;
		logic serial_clock;
		logic data_out;
	} driver_pins_type;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_SETUP,
		LINK_LOW,
		LINK_HIGH,
		LINK_BLOCK
	} link_state_type;

endpackage

// [microstep_wave_spi_out_sva.sv]
// Concurrent checks on the bus, step and serial link ports
`timescale 1ns/100ps
module microstep_wave_spi_out_sva
	import microstep_wave_pkg::*;
#(
	parameter int ADDR_WIDTH = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// Steps and currents
	input wire logic step_i,
	input wire logic direction_i,
	input wire logic [9:0] microstep_counter_o,
	input wire logic [8:0] phase_a_current_o,
	input wire logic [8:0] phase_b_current_o,
	// Link
	input wire logic driver_select_n_o,
	input wire logic driver_serial_clock_o
);
	serial_cfg_type cfg_reg;
	logic [31:0] start_reg;
	logic [4:0] low_cnt_reg;
	logic [4:0] high_cnt_reg;
	logic [7:0] gap_cnt_reg;
	logic first_reg;
	logic wr_done;
	assign wr_done = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	function automatic logic [4:0] eff(input logic [3:0] f);
		return (f < TIMING_MIN_CYCLES) ? {1'b0, TIMING_MIN_CYCLES} : {1'b0, f};
	endfunction
	// Registers are not visible here, so writes to the serial output configuration and start values are mirrored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= SERIAL_OUTPUT_CONFIG_RESET;
			start_reg <= WAVE_START_VALUES_RESET;
		end else if (wr_done && wb_adr_i[9:2] == IDX_SERIAL_OUTPUT_CONFIG) begin
			cfg_reg <= wb_dat_i;
		end else if (wr_done && wb_adr_i[9:2] == IDX_WAVE_START_VALUES) begin
			start_reg <= wb_dat_i;
		end
	end
	// Phase lengths of the serial clock and the gap between frames
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_reg <= 5'h00;
			high_cnt_reg <= 5'h00;
			gap_cnt_reg <= 8'h00;
			first_reg <= 1'b1;
		end else begin
			low_cnt_reg <= driver_serial_clock_o ? 5'h00 : low_cnt_reg + 5'h01;
			high_cnt_reg <= (driver_serial_clock_o && !driver_select_n_o) ? high_cnt_reg + 5'h01 : 5'h00;
			gap_cnt_reg <= !driver_select_n_o ? 8'h00 : ((gap_cnt_reg == 8'hff) ? gap_cnt_reg : gap_cnt_reg + 8'h01);
			first_reg <= driver_select_n_o ? 1'b1 : (driver_serial_clock_o && first_reg);
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_idle_lines_high: assert property (driver_select_n_o |-> driver_serial_clock_o)
		else $error("serial clock low outside a frame");
	a_low_time: assert property ($rose(driver_serial_clock_o) |-> low_cnt_reg == eff(cfg_reg.low_time))
		else $error("serial clock low time wrong");
	a_high_time: assert property ($fell(driver_serial_clock_o) |->
		high_cnt_reg == (first_reg ? eff(cfg_reg.low_time) : eff(cfg_reg.high_time)))
		else $error("serial clock high time or select lead wrong");
	a_block_gap: assert property ($fell(driver_select_n_o) |-> gap_cnt_reg >= {3'h0, eff(cfg_reg.block_time)})
		else $error("frames too close");
	a_step_counts: assert property (step_i |=> microstep_counter_o ==
		($past(direction_i) ? $past(microstep_counter_o) + 10'h001 : $past(microstep_counter_o) - 10'h001))
		else $error("counter did not follow step");
	a_zero_reload: assert property (($past(step_i) && microstep_counter_o == 10'h000) |->
		(phase_a_current_o == {1'b0, start_reg[7:0]} && phase_b_current_o == {1'b0, start_reg[23:16]}))
		else $error("currents not reloaded at zero");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus answer late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	cover property ($fell(driver_select_n_o));
	cover property ($past(step_i) && microstep_counter_o == 10'h000);
	cover property (wb_ack_o && wb_we_i);
endmodule
bind microstep_wave_spi_out microstep_wave_spi_out_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .step_i(step_i), .direction_i(direction_i), .microstep_counter_o(microstep_counter_o),
	.phase_a_current_o(phase_a_current_o), .phase_b_current_o(phase_b_current_o),
	.driver_select_n_o(driver_select_n_o), .driver_serial_clock_o(driver_serial_clock_o));

// [driver_slave_model.sv]
// Behavioural serial slave standing in for the motor driver
`timescale 1ns/100ps
module driver_slave_model #(
	parameter logic [31:0] RESPONSE = 32'ha5c3_0f96
) (
	// Link from the device
	input wire logic select_n_i,
	input wire logic serial_clock_i,
	input wire logic data_i,
	// Reply and capture
	output logic data_o,
	output logic [31:0] rx_word_o,
	output int frame_count_o
);
	logic [31:0] shift_reg = 32'h0;
	int bit_cnt = 0;
	initial begin
		data_o = 1'b0;
		rx_word_o = 32'h0;
		frame_count_o = 0;
	end
	// First reply bit is ready as soon as selected
	always @(negedge select_n_i) begin
		bit_cnt = 0;
		data_o = RESPONSE[31];
	end
	always @(negedge serial_clock_i) begin
		if (!select_n_i && bit_cnt > 0 && bit_cnt < 32) begin
			data_o = RESPONSE[31 - bit_cnt];
		end
	end
	always @(posedge serial_clock_i) begin
		if (!select_n_i) begin
			shift_reg = {shift_reg[30:0], data_i};
			bit_cnt++;
		end
	end
	// Released line flips so a stale bit cannot pass for a good one
	always @(posedge select_n_i) begin
		if (bit_cnt == 32) begin
			rx_word_o = shift_reg;
			frame_count_o++;
		end
		data_o = ~data_o;
	end
endmodule

// [microstep_wave_spi_out_tb.sv]
// Self-checking bench for the microstep wave generator and its serial output
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module microstep_wave_spi_out_tb;
	import microstep_wave_pkg::*;
	localparam logic [31:0] RESP = 32'ha5c3_0f96;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h000;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic step_i = 1'b0;
	logic direction_i = 1'b0;
	logic [9:0] microstep_counter_o;
	logic [8:0] phase_a_current_o;
	logic [8:0] phase_b_current_o;
	logic driver_select_n_o;
	logic driver_serial_clock_o;
	logic driver_data_out_o;
	logic driver_data_in_i;
	logic [31:0] rx_word;
	logic [31:0] rd;
	int n_frames;
	int frames;
	int fail_count = 0;
	int n_tests = 0;
	always #2 clk_i = ~clk_i;
	microstep_wave_spi_out u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .step_i(step_i), .direction_i(direction_i), .microstep_counter_o(microstep_counter_o),
		.phase_a_current_o(phase_a_current_o), .phase_b_current_o(phase_b_current_o),
		.driver_select_n_o(driver_select_n_o), .driver_serial_clock_o(driver_serial_clock_o),
		.driver_data_out_o(driver_data_out_o), .driver_data_in_i(driver_data_in_i));
	driver_slave_model #(.RESPONSE(RESP)) u_drv (.select_n_i(driver_select_n_o), .serial_clock_i(driver_serial_clock_o),
		.data_i(driver_data_out_o), .data_o(driver_data_in_i), .rx_word_o(rx_word), .frame_count_o(n_frames));
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		`CHK(wb_ack_o, 1'b1)
	endtask
	task automatic step(input logic up, input logic [9:0] cnt, input logic [8:0] a);
		@(posedge clk_i);
		step_i <= 1'b1;
		direction_i <= up;
		@(posedge clk_i);
		step_i <= 1'b0;
		#1;
		`CHK(microstep_counter_o, cnt)
		`CHK(phase_a_current_o, a)
	endtask
	// Polls busy and pending; a frame may be queued behind the one in flight
	task automatic wait_idle();
		do begin
			wb_xfer(1'b0, IDX_SERIAL_STATUS, 32'h0);
		end while (rd[1:0] !== 2'b00);
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		`CHK(microstep_counter_o, 10'h000)
		`CHK({phase_a_current_o, phase_b_current_o}, {9'h000, 9'h0f7})
		`CHK({driver_select_n_o, driver_serial_clock_o}, 2'b11)
		wb_xfer(1'b0, IDX_WAVE_SEGMENT_SELECT, 32'h0);
		`CHK(rd, 32'hffff_8056)
		wb_xfer(1'b0, IDX_WAVE_START_VALUES, 32'h0);
		`CHK(rd, 32'h00f7_0000)
		wb_xfer(1'b0, IDX_GENERAL_CONFIG, 32'h0);
		`CHK(rd[24], 1'b0)
		wb_xfer(1'b0, 8'h50, 32'h0);
		`CHK(rd, 32'h0)
		wb_xfer(1'b1, IDX_MICROSTEP_COUNTER, 32'h0000_03ff);
		wb_xfer(1'b0, IDX_MICROSTEP_COUNTER, 32'h0);
		`CHK(rd, 32'h0)
		wb_xfer(1'b1, IDX_SERIAL_OUTPUT_CONFIG, 32'h4230_0000);
		wb_xfer(1'b1, IDX_WAVE_START_VALUES, 32'h0064_0005);
		step(1'b1, 10'h001, 9'h001);
		step(1'b0, 10'h000, 9'h005);
		`CHK(phase_b_current_o, 9'h064)
		wb_xfer(1'b1, IDX_WAVE_TABLE_FIRST, 32'h0000_0001);
		step(1'b1, 10'h001, 9'h007);
		step(1'b0, 10'h000, 9'h005);
		wb_xfer(1'b1, IDX_WAVE_SEGMENT_SELECT, 32'hffff_8054);
		step(1'b1, 10'h001, 9'h005);
		step(1'b0, 10'h000, 9'h005);
		wb_xfer(1'b1, IDX_WAVE_TABLE_FIRST, 32'h0);
		step(1'b1, 10'h001, 9'h004);
		step(1'b0, 10'h000, 9'h005);
		wait_idle();
		`CHK(rx_word, 32'h0064_0005)
		wb_xfer(1'b0, IDX_DATAGRAM_RESPONSE, 32'h0);
		`CHK(rd, RESP)
		wb_xfer(1'b1, IDX_SERIAL_OUTPUT_CONFIG, 32'hff00_0000);
		step(1'b1, 10'h001, 9'h004);
		step(1'b0, 10'h000, 9'h005);
		wait_idle();
		`CHK(rx_word, 32'h0064_0005)
		wb_xfer(1'b0, IDX_DATAGRAM_RESPONSE, 32'h0);
		`CHK(rd, RESP)
		frames = n_frames;
		wb_xfer(1'b1, IDX_GENERAL_CONFIG, 32'h0100_0000);
		step(1'b1, 10'h001, 9'h004);
		repeat (10) @(posedge clk_i);
		`CHK(driver_select_n_o, 1'b1)
		`CHK(n_frames, frames)
		wb_xfer(1'b0, IDX_SERIAL_STATUS, 32'h0);
		`CHK(rd[1:0], 2'b00)
		wb_xfer(1'b1, IDX_WAVE_SEGMENT_SELECT, 32'hffff_9956);
		wb_xfer(1'b0, IDX_WAVE_SEGMENT_SELECT, 32'h0);
		`CHK(rd, 32'hffff_9956)
		tally_and_finish();
	end
endmodule
